/* include/rsf_pkg.sv */
// Shared constants and types for the rate sample filter and bias calibration block
`default_nettype none
package rsf_pkg;
    // Clock and sample timing
    localparam int CLK_HZ = 40_000_000;
    localparam int BASE_HZ = 32768;
    localparam int BASE_DIV = (CLK_HZ + BASE_HZ / 2) / BASE_HZ;
    localparam int BASE_W = $clog2(BASE_DIV);
    localparam int NVM_TIME_MS = 72;
    localparam int NVM_CYC = (CLK_HZ / 1000) * NVM_TIME_MS;

    // Register byte addresses, low byte of each 16-bit register
    localparam logic [6:0] ADDR_OUT_LO = 7'h04;
    localparam logic [6:0] ADDR_OUT_HI = 7'h06;
    localparam logic [6:0] ADDR_OFF_FINE = 7'h08;
    localparam logic [6:0] ADDR_OFF_COARSE = 7'h0a;
    localparam logic [6:0] ADDR_SMPL = 7'h1e;
    localparam logic [6:0] ADDR_FILT = 7'h20;
    localparam logic [6:0] ADDR_DEC = 7'h22;
    localparam logic [6:0] ADDR_CMD = 7'h28;

    // Reset values
    localparam logic [15:0] OFF_RST = 16'h0000;
    localparam logic [15:0] SMPL_RST = 16'h001f;
    localparam logic [15:0] FILT_RST = 16'h0000;
    localparam logic [15:0] DEC_RST = 16'h0000;

    // Field positions and limits
    localparam int CMD_ABC_BIT = 0;
    localparam int CMD_RESTORE_BIT = 1;
    localparam int FILT_EXP_W = 3;
    localparam int FILT_EXP_MAX = 6;
    localparam int DEC_EXP_W = 5;
    localparam int DEC_EXP_MAX = 16;
    localparam int DATA_W = 16;
    localparam int SPI_FRAME = 16;

    // Decoded serial frame: write flag, byte address, data byte
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } rsf_frame_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ABC = 3'b010,
        ST_SAVE = 3'b100
    } rsf_state_e;
endpackage
`default_nettype wire

/* verilog/rsf_sample_timer.sv */
// Sample tick generator: internal period divider or external sample clock
`timescale 1ns/100ps
`default_nettype none
module rsf_sample_timer (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Control
    input wire logic [15:0] i_period,
    input wire logic i_ext_pin,
    // Tick
    output logic o_tick
);
    logic [2:0] ext_q_r;
    logic [rsf_pkg::BASE_W-1:0] base_r, base_nxt;
    logic [15:0] pcnt_r, pcnt_nxt;
    logic tick_nxt;

    always_comb begin
        base_nxt = base_r;
        pcnt_nxt = pcnt_r;
        tick_nxt = 1'b0;
        if (i_period == 16'h0000) begin
            // Internal clock stopped, rising edges of the external pin time the samples
            base_nxt = '0;
            pcnt_nxt = 16'h0000;
            tick_nxt = ext_q_r[1] & ~ext_q_r[2];
        end else if (base_r == rsf_pkg::BASE_W'(rsf_pkg::BASE_DIV - 1)) begin
            base_nxt = '0;
            // Rate is base rate over code plus one
            if (pcnt_r >= i_period) begin
                pcnt_nxt = 16'h0000;
                tick_nxt = 1'b1;
            end else begin
                pcnt_nxt = pcnt_r + 16'h0001;
            end
        end else begin
            base_nxt = base_r + rsf_pkg::BASE_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ext_q_r <= 3'h0;
            base_r <= '0;
            pcnt_r <= 16'h0000;
            o_tick <= 1'b0;
        end else begin
            ext_q_r <= {ext_q_r[1:0], i_ext_pin};
            base_r <= base_nxt;
            pcnt_r <= pcnt_nxt;
            o_tick <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

/* verilog/rsf_avg_stage.sv */
// Moving average stage with power-of-two tap count
`timescale 1ns/100ps
`default_nettype none
module rsf_avg_stage #(
    parameter int W = 16,
    parameter int EXP_W = 3
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clr,
    // Control
    input wire logic [EXP_W-1:0] i_exp,
    // Sample stream
    input wire logic i_valid,
    input wire logic signed [W-1:0] i_data,
    output logic o_valid,
    output logic signed [W-1:0] o_data
);
    localparam int DEPTH = 64;
    localparam int PW = $clog2(DEPTH);
    localparam int SW = W + PW;

    logic signed [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] ptr_r, ptr_nxt, old_idx;
    logic signed [SW-1:0] sum_r, sum_nxt;
    logic [EXP_W-1:0] exp_r;
    logic flush;
    logic signed [W-1:0] data_nxt;

    // Tap count change or clear empties the history
    assign flush = i_clr | (exp_r != i_exp);
    assign old_idx = ptr_r - PW'(7'h01 << i_exp);

    always_comb begin
        ptr_nxt = ptr_r;
        sum_nxt = sum_r;
        data_nxt = o_data;
        if (flush) begin
            ptr_nxt = '0;
            sum_nxt = '0;
            data_nxt = '0;
        end else if (i_valid) begin
            ptr_nxt = ptr_r + PW'(1);
            sum_nxt = sum_r + SW'(i_data) - SW'(mem_r[old_idx]);
            data_nxt = W'(sum_nxt >>> i_exp);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_tap
            always_ff @(posedge i_sys_clk) begin
                if (i_rst || flush) begin
                    mem_r[gi] <= '0;
                end else if (i_valid && ptr_r == PW'(gi)) begin
                    mem_r[gi] <= i_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ptr_r <= '0;
            sum_r <= '0;
            exp_r <= '0;
            o_valid <= 1'b0;
            o_data <= '0;
        end else begin
            ptr_r <= ptr_nxt;
            sum_r <= sum_nxt;
            exp_r <= i_exp;
            o_valid <= i_valid & ~flush;
            o_data <= data_nxt;
        end
    end
endmodule
`default_nettype wire

/* verilog/rsf_top.sv */
// Rate sample timing, cascaded averaging, decimation, offsets and bias calibration
`timescale 1ns/100ps
`default_nettype none
module rsf_top #(
    parameter int NVM_CYC = rsf_pkg::NVM_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Serial port pins
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    // Sample timing pin
    input wire logic i_external_sample_clock_pin,
    // Sensor front end
    input wire logic signed [15:0] i_raw_rate,
    // Results and status
    output logic [15:0] o_rate_output_upper,
    output logic [15:0] o_rate_output_lower,
    output logic o_out_valid,
    output logic o_busy,
    output logic o_nvm_save
);
    localparam int TW = $clog2(NVM_CYC + 1);
    localparam int AW = 32;

    // Serial port synchronisers and shifter
    logic [2:0] sclk_q_r, cs_q_r;
    logic [1:0] mosi_q_r;
    logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic [4:0] bcnt_r, bcnt_nxt;
    logic [6:0] rd_addr_r, rd_addr_nxt;
    logic frm_vld_r, frm_vld_nxt;
    rsf_pkg::rsf_frame_s frm_r, frm_nxt;
    logic sclk_rise, sclk_fall, cs_fall, cs_act;

    // Registers and control
    logic [15:0] fine_r, fine_nxt, coarse_r, coarse_nxt;
    logic [15:0] smpl_r, smpl_nxt, filt_r, filt_nxt, dec_r, dec_nxt;
    logic [15:0] hi_nxt, lo_nxt;
    rsf_pkg::rsf_state_e state_r, state_nxt;
    logic [TW-1:0] timer_r, timer_nxt;
    logic save_nxt, vld_nxt, clr_r, clr_nxt;
    logic signed [AW-1:0] acc_r, acc_nxt, acc_sum, scaled;
    logic [AW-1:0] out_sum;
    logic [15:0] dcnt_r, dcnt_nxt, dlim;
    logic [rsf_pkg::DEC_EXP_W-1:0] dexp;

    // Datapath wiring
    logic tick;
    logic s1_vld, s2_vld;
    logic signed [15:0] s1_data, s2_data;

    assign sclk_rise = sclk_q_r[1] & ~sclk_q_r[2];
    assign sclk_fall = ~sclk_q_r[1] & sclk_q_r[2];
    assign cs_fall = ~cs_q_r[1] & cs_q_r[2];
    assign cs_act = ~cs_q_r[1];

    function automatic logic [15:0] rd_mux(input logic [6:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            rsf_pkg::ADDR_OUT_LO: v = o_rate_output_lower;
            rsf_pkg::ADDR_OUT_HI: v = o_rate_output_upper;
            rsf_pkg::ADDR_OFF_FINE: v = fine_r;
            rsf_pkg::ADDR_OFF_COARSE: v = coarse_r;
            rsf_pkg::ADDR_SMPL: v = smpl_r;
            rsf_pkg::ADDR_FILT: v = filt_r;
            rsf_pkg::ADDR_DEC: v = dec_r;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Byte write into one half of a 16-bit register
    function automatic logic [15:0] put_byte(input logic [15:0] r, input logic hi,
                                             input logic [7:0] d);
        return hi ? {d, r[7:0]} : {r[15:8], d};
    endfunction

    always_comb begin
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        bcnt_nxt = bcnt_r;
        frm_vld_nxt = 1'b0;
        frm_nxt = frm_r;
        if (!cs_act) begin
            bcnt_nxt = 5'h00;
        end else begin
            if (cs_fall) begin
                tx_nxt = rd_mux(rd_addr_r);
            end
            if (sclk_rise) begin
                rx_nxt = {rx_r[14:0], mosi_q_r[1]};
                if (bcnt_r == 5'(rsf_pkg::SPI_FRAME - 1)) begin
                    frm_vld_nxt = 1'b1;
                    frm_nxt = rsf_pkg::rsf_frame_s'({rx_r[14:0], mosi_q_r[1]});
                    bcnt_nxt = 5'h00;
                end else begin
                    bcnt_nxt = bcnt_r + 5'h01;
                end
            end
            // First bit stays up until the first sampling edge
            if (sclk_fall && bcnt_r != 5'h00) begin
                tx_nxt = {tx_r[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sclk_q_r <= 3'h7;
            cs_q_r <= 3'h7;
            mosi_q_r <= 2'h0;
            rx_r <= 16'h0000;
            tx_r <= 16'h0000;
            bcnt_r <= 5'h00;
            frm_vld_r <= 1'b0;
            frm_r <= '0;
        end else begin
            sclk_q_r <= {sclk_q_r[1:0], i_spi_sclk};
            cs_q_r <= {cs_q_r[1:0], i_spi_cs_n};
            mosi_q_r <= {mosi_q_r[0], i_spi_mosi};
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            bcnt_r <= bcnt_nxt;
            frm_vld_r <= frm_vld_nxt;
            frm_r <= frm_nxt;
        end
    end

    assign o_spi_miso = tx_r[15];

    rsf_sample_timer u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_period(smpl_r),
        .i_ext_pin(i_external_sample_clock_pin),
        .o_tick(tick)
    );

    // Two identical stages in cascade
    rsf_avg_stage #(.W(rsf_pkg::DATA_W), .EXP_W(rsf_pkg::FILT_EXP_W)) u_stage1 (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clr(clr_r),
        .i_exp(filt_r[rsf_pkg::FILT_EXP_W-1:0]),
        .i_valid(tick),
        .i_data(i_raw_rate),
        .o_valid(s1_vld),
        .o_data(s1_data)
    );

    rsf_avg_stage #(.W(rsf_pkg::DATA_W), .EXP_W(rsf_pkg::FILT_EXP_W)) u_stage2 (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clr(clr_r),
        .i_exp(filt_r[rsf_pkg::FILT_EXP_W-1:0]),
        .i_valid(s1_vld),
        .i_data(s1_data),
        .o_valid(s2_vld),
        .o_data(s2_data)
    );

    // Decimation group size and output scaling
    assign dexp = dec_r[rsf_pkg::DEC_EXP_W-1:0];
    assign dlim = 16'((17'h00001 << dexp) - 17'h00001);
    assign acc_sum = acc_r + AW'(s2_data);
    // Growth bits land MSB-first in the lower word
    assign scaled = acc_sum <<< (5'(rsf_pkg::DEC_EXP_MAX) - dexp);
    assign out_sum = AW'(scaled) + {coarse_r, fine_r};

    always_comb begin
        fine_nxt = fine_r;
        coarse_nxt = coarse_r;
        smpl_nxt = smpl_r;
        filt_nxt = filt_r;
        dec_nxt = dec_r;
        hi_nxt = o_rate_output_upper;
        lo_nxt = o_rate_output_lower;
        state_nxt = state_r;
        timer_nxt = timer_r;
        save_nxt = 1'b0;
        vld_nxt = 1'b0;
        clr_nxt = 1'b0;
        acc_nxt = acc_r;
        dcnt_nxt = dcnt_r;
        if (s2_vld) begin
            if (dcnt_r >= dlim) begin
                acc_nxt = '0;
                dcnt_nxt = 16'h0000;
                vld_nxt = 1'b1;
                hi_nxt = out_sum[31:16];
                lo_nxt = out_sum[15:0];
            end else begin
                acc_nxt = acc_sum;
                dcnt_nxt = dcnt_r + 16'h0001;
            end
        end
        unique case (state_r)
            rsf_pkg::ST_IDLE: begin
                if (frm_vld_r && frm_r.wr) begin
                    unique case ({frm_r.addr[6:1], 1'b0})
                        rsf_pkg::ADDR_OFF_FINE:
                            fine_nxt = put_byte(fine_r, frm_r.addr[0], frm_r.data);
                        rsf_pkg::ADDR_OFF_COARSE:
                            coarse_nxt = put_byte(coarse_r, frm_r.addr[0], frm_r.data);
                        rsf_pkg::ADDR_SMPL:
                            smpl_nxt = put_byte(smpl_r, frm_r.addr[0], frm_r.data);
                        rsf_pkg::ADDR_FILT:
                            filt_nxt = put_byte(filt_r, frm_r.addr[0], frm_r.data);
                        rsf_pkg::ADDR_DEC:
                            dec_nxt = put_byte(dec_r, frm_r.addr[0], frm_r.data);
                        rsf_pkg::ADDR_CMD: begin
                            if (!frm_r.addr[0] && frm_r.data[rsf_pkg::CMD_RESTORE_BIT]) begin
                                fine_nxt = rsf_pkg::OFF_RST;
                                coarse_nxt = rsf_pkg::OFF_RST;
                                hi_nxt = 16'h0000;
                                lo_nxt = 16'h0000;
                                acc_nxt = '0;
                                dcnt_nxt = 16'h0000;
                                clr_nxt = 1'b1;
                                save_nxt = 1'b1;
                                timer_nxt = TW'(NVM_CYC - 1);
                                state_nxt = rsf_pkg::ST_SAVE;
                            end else if (!frm_r.addr[0] &&
                                         frm_r.data[rsf_pkg::CMD_ABC_BIT]) begin
                                // Fresh group so a whole output cycle is measured
                                acc_nxt = '0;
                                dcnt_nxt = 16'h0000;
                                state_nxt = rsf_pkg::ST_ABC;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            rsf_pkg::ST_ABC: begin
                // Serial frames are dropped until the sequence ends
                if (vld_nxt) begin
                    {coarse_nxt, fine_nxt} = 32'(-scaled);
                    save_nxt = 1'b1;
                    timer_nxt = TW'(NVM_CYC - 1);
                    state_nxt = rsf_pkg::ST_SAVE;
                end
            end
            rsf_pkg::ST_SAVE: begin
                if (timer_r == '0) begin
                    state_nxt = rsf_pkg::ST_IDLE;
                end else begin
                    timer_nxt = timer_r - TW'(1);
                end
            end
            default: begin
                state_nxt = rsf_pkg::ST_IDLE;
            end
        endcase
        if (frm_vld_r && !frm_r.wr && state_r == rsf_pkg::ST_IDLE) begin
            rd_addr_nxt = {frm_r.addr[6:1], 1'b0};
        end else begin
            rd_addr_nxt = rd_addr_r;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            fine_r <= rsf_pkg::OFF_RST;
            coarse_r <= rsf_pkg::OFF_RST;
            smpl_r <= rsf_pkg::SMPL_RST;
            filt_r <= rsf_pkg::FILT_RST;
            dec_r <= rsf_pkg::DEC_RST;
            o_rate_output_upper <= 16'h0000;
            o_rate_output_lower <= 16'h0000;
            state_r <= rsf_pkg::ST_IDLE;
            timer_r <= '0;
            o_nvm_save <= 1'b0;
            o_out_valid <= 1'b0;
            o_busy <= 1'b0;
            clr_r <= 1'b0;
            acc_r <= '0;
            dcnt_r <= 16'h0000;
            rd_addr_r <= 7'h00;
        end else begin
            fine_r <= fine_nxt;
            coarse_r <= coarse_nxt;
            smpl_r <= smpl_nxt;
            filt_r <= filt_nxt;
            dec_r <= dec_nxt;
            o_rate_output_upper <= hi_nxt;
            o_rate_output_lower <= lo_nxt;
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            o_nvm_save <= save_nxt;
            o_out_valid <= vld_nxt;
            o_busy <= (state_nxt != rsf_pkg::ST_IDLE);
            clr_r <= clr_nxt;
            acc_r <= acc_nxt;
            dcnt_r <= dcnt_nxt;
            rd_addr_r <= rd_addr_nxt;
        end
    end
endmodule
`default_nettype wire

/* verif/rsf_host_model.sv */
// Serial host model: mode 3 master that sends 16-bit register frames, each carrying one data byte
`timescale 1ns/100ps
`default_nettype none
module rsf_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Serial pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // One frame, MSB first, clock halves of 5 cycles
    task automatic xfer(input logic [15:0] din, output logic [15:0] dout);
        tick(1);
        o_cs_n = 1'b0;
        tick(5);
        for (int i = 15; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_mosi = din[i];
            tick(5);
            o_sclk = 1'b1;
            dout[i] = i_miso;
            tick(5);
        end
        o_cs_n = 1'b1;
        // Released data line keeps moving
        o_mosi = ~o_mosi;
        tick(6);
    endtask

    task automatic wr16(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] d;
        xfer({1'b1, a, v[7:0]}, d);
        xfer({1'b1, a + 7'h01, v[15:8]}, d);
    endtask

    // Answer arrives in the frame after the read command
    task automatic rd16(input logic [6:0] a, output logic [15:0] v);
        logic [15:0] d;
        xfer({1'b0, a, 8'h00}, d);
        xfer(16'h0000, v);
    endtask
endmodule
`default_nettype wire

/* verif/rsf_top_sva.sv */
// Checker for output update, save and busy timing
`timescale 1ns/100ps
`default_nettype none
module rsf_top_sva #(
    parameter int NVM_CYC = 20
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Observed outputs
    input wire logic [15:0] o_rate_output_upper,
    input wire logic [15:0] o_rate_output_lower,
    input wire logic o_out_valid,
    input wire logic o_busy,
    input wire logic o_nvm_save
);
    int busy_cnt_r;
    int busy_cnt_nxt;

    // Busy cycles since the save pulse
    always_comb begin
        busy_cnt_nxt = busy_cnt_r;
        if (o_nvm_save)
            busy_cnt_nxt = 0;
        else if (o_busy)
            busy_cnt_nxt = busy_cnt_r + 1;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst)
            busy_cnt_r <= 0;
        else
            busy_cnt_r <= busy_cnt_nxt;
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_save_start;
        o_nvm_save;
    endsequence

    sequence s_save_run;
        o_busy[*8];
    endsequence

    a_save_holds_busy: assert property (s_save_start |=> s_save_run)
        else $error("busy dropped during save");
    a_save_in_busy: assert property (s_save_start |-> ##[0:1] o_busy)
        else $error("save pulse outside busy");
    a_save_single: assert property (o_nvm_save |=> !o_nvm_save)
        else $error("save pulse longer than one cycle");
    a_valid_single: assert property (o_out_valid |=> !o_out_valid)
        else $error("output valid longer than one cycle");
    a_upper_holds: assert property ((!o_out_valid && !o_busy && !$past(o_busy)) |->
        $stable(o_rate_output_upper)) else $error("upper word changed without update");
    a_lower_holds: assert property ((!o_out_valid && !o_busy && !$past(o_busy)) |->
        $stable(o_rate_output_lower)) else $error("lower word changed without update");
    a_reset_clears: assert property ($fell(i_rst) |->
        (o_rate_output_upper == 16'h0000 && !o_busy && !o_out_valid))
        else $error("outputs not cleared by reset");
    a_busy_length: assert property ($fell(o_busy) |->
        busy_cnt_r inside {[NVM_CYC - 1:NVM_CYC + 2]}) else $error("save time wrong");
endmodule

bind rsf_top rsf_top_sva #(.NVM_CYC(NVM_CYC)) u_sva (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .o_rate_output_upper(o_rate_output_upper),
    .o_rate_output_lower(o_rate_output_lower),
    .o_out_valid(o_out_valid),
    .o_busy(o_busy),
    .o_nvm_save(o_nvm_save)
);
`default_nettype wire

/* verif/rsf_top_tb_top.sv */
// Testbench for the rate filter and bias calibration block
`timescale 1ns/100ps
`default_nettype none
module rsf_top_tb_top;
    logic clk, rst, sclk, cs_n, mosi, miso, ext, valid, busy, save;
    logic signed [15:0] raw;
    logic [15:0] up, lo, d;
    int mismatches, n_compared, saves, vcnt, cyc, vt, vgap;
    logic [6:0] ra [7] = '{7'h08, 7'h0a, 7'h1e, 7'h20, 7'h22, 7'h28, 7'h0c};
    logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h001f, 16'h0000, 16'h0000, 16'h0000,
        16'h0000};

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    rsf_top #(.NVM_CYC(20)) DUT (
        .i_sys_clk(clk),
        .i_rst(rst),
        .i_spi_sclk(sclk),
        .i_spi_cs_n(cs_n),
        .i_spi_mosi(mosi),
        .o_spi_miso(miso),
        .i_external_sample_clock_pin(ext),
        .i_raw_rate(raw),
        .o_rate_output_upper(up),
        .o_rate_output_lower(lo),
        .o_out_valid(valid),
        .o_busy(busy),
        .o_nvm_save(save)
    );

    rsf_host_model host (
        .i_sys_clk(clk),
        .o_sclk(sclk),
        .o_cs_n(cs_n),
        .o_mosi(mosi),
        .i_miso(miso)
    );

    always @(posedge clk) begin
        cyc++;
        if (valid === 1'b1) begin
            vcnt++;
            vgap = cyc - vt;
            vt = cyc;
        end
        if (save === 1'b1)
            saves++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One external sample edge with the raw value held
    task automatic smp(input logic [15:0] x);
        host.tick(1);
        raw = x;
        ext = 1'b1;
        host.tick(4);
        ext = 1'b0;
        host.tick(8);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            host.tick(1);
        if (busy !== 1'b0) begin
            mismatches++;
            $display("MISMATCH t=%0t busy never fell", $time);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #2_000_000;
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        ext = 1'b0;
        raw = 16'h0000;
        {mismatches, n_compared, saves, vcnt, cyc, vt, vgap} = '0;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        host.tick(4);
        for (int i = 0; i < 7; i++) begin
            host.rd16(ra[i], d);
            chk(d, rv[i]);
        end
        $display("reset values done");
        host.wr16(7'h1e, 16'h0000);
        host.wr16(7'h0a, 16'h0005);
        host.wr16(7'h08, 16'h8000);
        host.wr16(7'h20, 16'hfff9);
        host.xfer({1'b1, 7'h29, 8'h03}, d);
        host.rd16(7'h0a, d);
        chk(d, 16'h0005);
        vcnt = 0;
        smp(16'h0100);
        chk(up, 16'h0045);
        chk(lo, 16'h8000);
        smp(16'h0200);
        chk(up, 16'h0105);
        chk(16'(vcnt), 16'h0002);
        host.rd16(7'h04, d);
        chk(d, 16'h8000);
        $display("filter test done");
        host.wr16(7'h20, 16'h0000);
        host.wr16(7'h22, 16'hffe2);
        vcnt = 0;
        for (int k = 0; k < 4; k++)
            smp(16'h0100 + 16'(k));
        chk(16'(vcnt), 16'h0001);
        chk(up, 16'h0107);
        chk(lo, 16'h0000);
        host.rd16(7'h06, d);
        chk(d, 16'h0107);
        $display("decimation test done");
        host.xfer(16'ha801, d);
        chk({15'h0000, busy}, 16'h0001);
        host.xfer({1'b1, 7'h0a, 8'h34}, d);
        for (int k = 0; k < 4; k++)
            smp(16'hfff0);
        wait_idle();
        chk(16'(saves), 16'h0001);
        host.rd16(7'h0a, d);
        chk(d, 16'h0010);
        host.rd16(7'h08, d);
        chk(d, 16'h0000);
        for (int k = 0; k < 4; k++)
            smp(16'hfff1);
        chk(up, 16'h0001);
        $display("correction test done");
        host.xfer(16'ha802, d);
        wait_idle();
        chk(16'(saves), 16'h0002);
        chk(up, 16'h0000);
        host.rd16(7'h0a, d);
        chk(d, 16'h0000);
        $display("restore test done");
        host.xfer(16'ha801, d);
        chk({15'h0000, busy}, 16'h0001);
        rst = 1'b1;
        host.tick(3);
        rst = 1'b0;
        host.tick(4);
        chk({15'h0000, busy}, 16'h0000);
        host.rd16(7'h1e, d);
        chk(d, 16'h001f);
        $display("reset abort test done");
        host.wr16(7'h22, 16'h0000);
        host.wr16(7'h1e, 16'h000f);
        vcnt = 0;
        for (int i = 0; i < 60000 && vcnt < 2; i++) begin
            // Pin edges must be ignored while the internal timer runs
            ext = 1'((i / 100) % 2);
            host.tick(1);
        end
        chk(16'(vgap), 16'd19536);
        $display("sample timer test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
